/* File: hdl/power_ctrl_pkg.sv */
// Shared constants and types of the power mode and output control block.
// Assumes one core clock and a register write port fed by the serial decoder.
package power_ctrl_pkg;

    // Widths.
    localparam int NUM_CHANNELS = 6;
    localparam int CODE_W = 8;
    localparam int BOOST_W = 4;
    localparam int VOLTS_W = 5;
    localparam int ENABLE_W = 6;
    localparam int STATE_W = 2;
    localparam int ADDR_W = 4;
    localparam int LEVEL_W = 15;
    localparam int COUNT_W = 4;

    // Register indices on the write and read ports.
    localparam logic [ADDR_W-1:0] REG_BOOST_LEVEL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_POWER_STATE = 4'h1;
    localparam logic [ADDR_W-1:0] REG_OUTPUT_ENABLES = 4'h2;
    localparam logic [ADDR_W-1:0] REG_CHANNEL_A_CODE = 4'h3;
    localparam logic [ADDR_W-1:0] REG_CHANNEL_F_CODE = 4'h8;

    // Reset values.
    localparam logic [BOOST_W-1:0] BOOST_LEVEL_RESET = 4'hF;
    localparam logic [ENABLE_W-1:0] OUTPUT_ENABLES_RESET = 6'h00;
    localparam logic [CODE_W-1:0] CHANNEL_CODE_RESET = 8'h00;

    // Power state codes as read and written by software.
    localparam logic [STATE_W-1:0] PSTATE_ACTIVE = 2'h0;
    localparam logic [STATE_W-1:0] PSTATE_STARTUP = 2'h1;
    localparam logic [STATE_W-1:0] PSTATE_LOW_POWER = 2'h2;

    // Boost target: base volts plus one volt per code step.
    localparam logic [VOLTS_W-1:0] BOOST_BASE_VOLTS = 5'h09;

    // Output code scaling.
    localparam logic [CODE_W-1:0] CODE_PULL_DOWN = 8'h00;
    localparam logic [CODE_W-1:0] CODE_MAX_USABLE = 8'h7F;
    localparam logic [LEVEL_W-1:0] OUT_STEP_MV = 15'h00BC;

    // Last startup count before active is entered; startup lasts one cycle longer.
    localparam logic [COUNT_W-1:0] STARTUP_CYCLES = 4'h4;

    typedef enum logic [3:0] {
        ST_SHUTDOWN = 4'b0001,
        ST_STARTUP = 4'b0010,
        ST_ACTIVE = 4'b0100,
        ST_LOW_POWER = 4'b1000
    } power_mode_e;

    typedef enum logic [1:0] {
        OUT_HIGH_Z = 2'h0,
        OUT_PULL_DOWN = 2'h1,
        OUT_DRIVE = 2'h2
    } output_drive_e;

    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] addr;
        logic [CODE_W-1:0] data;
    } reg_write_s;

    typedef struct packed {
        output_drive_e drive;
        logic [LEVEL_W-1:0] level_mv;
    } channel_out_s;

endpackage : power_ctrl_pkg

/* File: hdl/supply_sync.sv */
// Two-flop synchroniser for supply-presence levels.
// Assumes the inputs are asynchronous to core_clk_in.
`timescale 1ns/1ps
`default_nettype none
module supply_sync #(
    parameter int WIDTH = 2
) (
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic reset_in,
    // Asynchronous levels and their synchronised copies.
    input wire logic [WIDTH-1:0] level_in,
    output logic [WIDTH-1:0] level_out
);
    logic [WIDTH-1:0] stage_one;

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            stage_one <= '0;
            level_out <= '0;
        end else begin
            stage_one <= level_in;
            level_out <= stage_one;
        end
    end
endmodule : supply_sync
`default_nettype wire

/* File: hdl/output_channel.sv */
// One high-voltage output channel: drive mode and target level.
// Assumes active_in is high only while the block is in active mode.
`timescale 1ns/1ps
`default_nettype none
module output_channel
    import power_ctrl_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic reset_in,
    // Control from the mode machine and the register set.
    input wire logic active_in,
    input wire logic enable_in,
    input wire logic [CODE_W-1:0] code_in,
    // Channel result.
    output channel_out_s channel_out
);
    logic [CODE_W-1:0] usable_code;
    logic [LEVEL_W-1:0] wide_code;
    logic [LEVEL_W-1:0] next_level;
    output_drive_e next_drive;

    // Codes past the last usable step are held at full scale.
    assign usable_code = (code_in > CODE_MAX_USABLE) ? CODE_MAX_USABLE : code_in; // RL3
    assign wide_code = {{(LEVEL_W-CODE_W){1'b0}}, usable_code};
    assign next_level = wide_code * OUT_STEP_MV; // RL3
    assign next_drive = (!active_in || !enable_in) ? OUT_HIGH_Z : // RL9
                        (code_in == CODE_PULL_DOWN) ? OUT_PULL_DOWN : // RL4
                        OUT_DRIVE;

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            channel_out <= '{drive: OUT_HIGH_Z, level_mv: '0};
        end else begin
            channel_out <= '{drive: next_drive, level_mv: next_level};
        end
    end
endmodule : output_channel
`default_nettype wire

/* File: hdl/power_mode_and_output_control.sv */
// Mode controller and control registers of a six-output bias chip.
// Assumes a serial decoder on core_clk_in presents register writes and
// reads, and that both supply-presence levels arrive asynchronously.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// RL1: Boost target is nine volts plus code.
// RL2: Boost level resets to all ones.
// RL3: Output level is code times 188 mV.
// RL4: Code zero pulls an enabled output down.
// RL5: Shutdown on main supply or low I/O.
// RL6: Startup resets registers, boost on, outputs off.
// RL7: Startup moves to active on its own.
// RL8: Startup command gives full reset, then active.
// RL9: Active outputs follow codes once enabled.
// RL10: Low power leaves only on active command; the code also leaves it on a startup command.
// RL11: Low power: serial on, outputs, boost off.
// RL12: Low power entered from active, keeps registers.
// RL13: I/O rising edge resets serial logic.
// RL14: Power state reads startup, then active.
// RL15: Enables reset to zero, outputs high impedance.
// RL16: Host keeps boost two volts above outputs.
// RL17: Shutdown ignores all register writes.
module power_mode_and_output_control
    import power_ctrl_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic reset_in,
    // Supply presence, asynchronous.
    input wire logic io_supply_in,
    input wire logic main_supply_in,
    // Register port from the serial decoder.
    input wire reg_write_s reg_write_in,
    input wire logic [ADDR_W-1:0] reg_read_addr_in,
    output logic [CODE_W-1:0] reg_read_data_out,
    // Serial interface control.
    output logic serial_enable_out,
    output logic serial_reset_out,
    // Boost converter control.
    output logic boost_enable_out,
    output logic [VOLTS_W-1:0] boost_target_volts_out,
    // Mode and channel results.
    output logic [STATE_W-1:0] power_state_out,
    output channel_out_s [NUM_CHANNELS-1:0] channels_out
);

    // Synchronised supplies and their edge history.
    logic [1:0] supply_raw;
    logic [1:0] supply_sync_level;
    logic io_supply;
    logic main_supply;
    logic io_supply_prev;
    logic main_supply_prev;
    logic io_rise;
    logic main_rise;

    // Mode machine.
    power_mode_e mode;
    power_mode_e next_mode;
    logic [COUNT_W-1:0] startup_count;
    logic [COUNT_W-1:0] next_startup_count;
    logic startup_done;

    // Register set.
    logic [BOOST_W-1:0] boost_level;
    logic [ENABLE_W-1:0] output_enables;
    logic [CODE_W-1:0] channel_code [NUM_CHANNELS];

    // Write decode.
    logic write_allowed;
    logic write_boost;
    logic write_enables;
    logic write_power;
    logic [STATE_W-1:0] power_command;
    logic cmd_startup;
    logic cmd_active;
    logic cmd_low_power;
    logic [ADDR_W-1:0] channel_index;
    logic channel_hit;
    logic clear_registers;

    // Derived mode levels.
    logic in_shutdown;
    logic in_startup;
    logic in_active;
    logic in_low_power;
    logic [STATE_W-1:0] power_state;
    logic [CODE_W-1:0] next_read_data;

    // Supply synchronisation.
    assign supply_raw = {main_supply_in, io_supply_in};

    supply_sync #(
        .WIDTH(2)
    ) supply_sync_inst (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .level_in(supply_raw),
        .level_out(supply_sync_level)
    );

    assign io_supply = supply_sync_level[0];
    assign main_supply = supply_sync_level[1];

    // Only a low-to-high move of the I/O supply starts the chip, so a
    // supply that sags without reaching low never restarts it.
    assign io_rise = io_supply && !io_supply_prev; // RL13
    assign main_rise = main_supply && !main_supply_prev; // RL5

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            io_supply_prev <= 1'b0;
            main_supply_prev <= 1'b0;
        end else begin
            io_supply_prev <= io_supply;
            main_supply_prev <= main_supply;
        end
    end

    // Mode levels.
    assign in_shutdown = (mode == ST_SHUTDOWN);
    assign in_startup = (mode == ST_STARTUP);
    assign in_active = (mode == ST_ACTIVE);
    assign in_low_power = (mode == ST_LOW_POWER);
    assign startup_done = (startup_count == STARTUP_CYCLES);

    // Write decode; nothing is taken in shutdown or while startup clears.
    assign write_allowed = reg_write_in.valid && (in_active || in_low_power); // RL17
    assign write_boost = write_allowed && (reg_write_in.addr == REG_BOOST_LEVEL);
    assign write_enables = write_allowed && (reg_write_in.addr == REG_OUTPUT_ENABLES);
    assign write_power = write_allowed && (reg_write_in.addr == REG_POWER_STATE);
    assign power_command = reg_write_in.data[STATE_W-1:0];
    assign cmd_startup = write_power && (power_command == PSTATE_STARTUP); // RL8
    assign cmd_active = write_power && (power_command == PSTATE_ACTIVE); // RL10
    assign cmd_low_power = write_power && (power_command == PSTATE_LOW_POWER); // RL12
    assign channel_hit = write_allowed && (reg_write_in.addr >= REG_CHANNEL_A_CODE)
                         && (reg_write_in.addr <= REG_CHANNEL_F_CODE);
    assign channel_index = reg_write_in.addr - REG_CHANNEL_A_CODE;

    // Registers are lost in shutdown and set to defaults during startup.
    assign clear_registers = in_shutdown || in_startup; // RL5 RL6

    // Mode transitions. A low I/O supply or a fresh main supply wins over
    // everything, including a command written in the same cycle. An I/O rise
    // in that same cycle still starts up, so both supplies up at reset start.
    always_comb begin
        next_mode = mode;
        next_startup_count = startup_count;
        if (!io_supply || (main_rise && !io_rise)) begin
            next_mode = ST_SHUTDOWN; // RL5
            next_startup_count = '0;
        end else begin
            case (mode)
                ST_SHUTDOWN: begin
                    if (io_rise) begin
                        next_mode = ST_STARTUP; // RL6
                        next_startup_count = '0;
                    end
                end
                ST_STARTUP: begin
                    if (startup_done) begin
                        next_mode = ST_ACTIVE; // RL7
                    end else begin
                        next_startup_count = startup_count + 4'h1;
                    end
                end
                ST_ACTIVE: begin
                    if (cmd_startup) begin
                        next_mode = ST_STARTUP; // RL8
                        next_startup_count = '0;
                    end else if (cmd_low_power) begin
                        next_mode = ST_LOW_POWER; // RL12
                    end
                end
                ST_LOW_POWER: begin
                    if (cmd_startup) begin
                        next_mode = ST_STARTUP; // RL8
                        next_startup_count = '0;
                    end else if (cmd_active) begin
                        next_mode = ST_ACTIVE; // RL10
                    end
                end
                default: begin
                    next_mode = ST_SHUTDOWN;
                    next_startup_count = '0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            mode <= ST_SHUTDOWN;
            startup_count <= '0;
        end else begin
            mode <= next_mode;
            startup_count <= next_startup_count;
        end
    end

    // Boost level and output enables.
    always_ff @(posedge core_clk_in) begin
        if (reset_in || clear_registers) begin
            boost_level <= BOOST_LEVEL_RESET; // RL2
            output_enables <= OUTPUT_ENABLES_RESET; // RL15
        end else begin
            if (write_boost) begin
                boost_level <= reg_write_in.data[BOOST_W-1:0];
            end
            if (write_enables) begin
                output_enables <= reg_write_in.data[ENABLE_W-1:0];
            end
        end
    end

    // Channel code registers, one per output, held through low power.
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CHANNELS; ch++) begin : gen_code
            always_ff @(posedge core_clk_in) begin
                if (reset_in || clear_registers) begin
                    channel_code[ch] <= CHANNEL_CODE_RESET; // RL15
                end else if (channel_hit && (channel_index == ADDR_W'(ch))) begin
                    channel_code[ch] <= reg_write_in.data; // RL9 RL12
                end
            end

            output_channel output_channel_inst (
                .core_clk_in(core_clk_in),
                .reset_in(reset_in),
                .active_in(in_active), // RL6 RL11
                .enable_in(output_enables[ch]), // RL9
                .code_in(channel_code[ch]),
                .channel_out(channels_out[ch])
            );
        end
    endgenerate

    // Power state field as software sees it.
    always_comb begin
        case (mode)
            ST_STARTUP: power_state = PSTATE_STARTUP; // RL14
            ST_LOW_POWER: power_state = PSTATE_LOW_POWER;
            ST_ACTIVE: power_state = PSTATE_ACTIVE; // RL14
            default: power_state = PSTATE_ACTIVE;
        endcase
    end

    // Register read mux; unmapped indices and shutdown read as zero.
    always_comb begin
        next_read_data = '0;
        if (!in_shutdown) begin
            if (reg_read_addr_in == REG_BOOST_LEVEL) begin
                next_read_data = {{(CODE_W-BOOST_W){1'b0}}, boost_level};
            end else if (reg_read_addr_in == REG_POWER_STATE) begin
                next_read_data = {{(CODE_W-STATE_W){1'b0}}, power_state};
            end else if (reg_read_addr_in == REG_OUTPUT_ENABLES) begin
                next_read_data = {{(CODE_W-ENABLE_W){1'b0}}, output_enables};
            end else if ((reg_read_addr_in >= REG_CHANNEL_A_CODE)
                         && (reg_read_addr_in <= REG_CHANNEL_F_CODE)) begin
                for (int i = 0; i < NUM_CHANNELS; i++) begin
                    if (reg_read_addr_in == (REG_CHANNEL_A_CODE + i[ADDR_W-1:0])) begin
                        next_read_data = channel_code[i];
                    end
                end
            end
        end
    end

    // Outputs. The serial logic is held in reset through shutdown and
    // startup, which covers both the supply event and the soft reset.
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            reg_read_data_out <= '0;
            serial_enable_out <= 1'b0;
            serial_reset_out <= 1'b1;
            boost_enable_out <= 1'b0;
            boost_target_volts_out <= BOOST_BASE_VOLTS + {1'b0, BOOST_LEVEL_RESET};
            power_state_out <= PSTATE_ACTIVE;
        end else begin
            reg_read_data_out <= next_read_data;
            serial_enable_out <= !in_shutdown; // RL6 RL11
            serial_reset_out <= in_shutdown || in_startup; // RL13
            boost_enable_out <= in_startup || in_active; // RL6 RL11
            boost_target_volts_out <= BOOST_BASE_VOLTS + {1'b0, boost_level}; // RL1
            power_state_out <= power_state; // RL14
        end
    end

endmodule : power_mode_and_output_control
`default_nettype wire

/* File: tb/power_ctrl_props.sv */
// Checker of the power mode block, bound to its top-level ports.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module power_ctrl_props
    import power_ctrl_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic reset_in,
    // Watched ports.
    input wire logic io_supply_in,
    input wire reg_write_s reg_write_in,
    input wire logic [ADDR_W-1:0] reg_read_addr_in,
    input wire logic [CODE_W-1:0] reg_read_data_out,
    input wire logic serial_enable_out,
    input wire logic serial_reset_out,
    input wire logic boost_enable_out,
    input wire logic [VOLTS_W-1:0] boost_target_volts_out,
    input wire logic [STATE_W-1:0] power_state_out,
    input wire channel_out_s [NUM_CHANNELS-1:0] channels_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (reset_in);
    logic [NUM_CHANNELS-1:0] off_bits;
    for (genvar i = 0; i < NUM_CHANNELS; i++) begin : g_ch
        assign off_bits[i] = channels_out[i].drive == OUT_HIGH_Z;
        pull_down_a: assert property (
            channels_out[i].drive == OUT_PULL_DOWN |-> channels_out[i].level_mv == 15'h0000)
            else $error("pulled-down output has a level");
        drive_level_a: assert property (
            channels_out[i].drive == OUT_DRIVE |-> channels_out[i].level_mv != 15'h0000
            && channels_out[i].level_mv % OUT_STEP_MV == 15'h0000
            && channels_out[i].level_mv <= 15'h5D44)
            else $error("driven level off the step grid");
    end
    sequence startup_run;
        (power_state_out == PSTATE_STARTUP) [*5] ##1 (power_state_out == PSTATE_ACTIVE);
    endsequence
    startup_exit_a: assert property (
        $rose(power_state_out == PSTATE_STARTUP) |-> startup_run)
        else $error("startup did not last five cycles then go active");
    startup_outputs_a: assert property (
        power_state_out == PSTATE_STARTUP |-> &off_bits && boost_enable_out
        && serial_reset_out && serial_enable_out)
        else $error("wrong outputs in startup");
    shutdown_off_a: assert property (
        !io_supply_in [*6] |-> &off_bits && !serial_enable_out && !boost_enable_out)
        else $error("block still on with io supply low");
    low_power_outputs_a: assert property (
        power_state_out == PSTATE_LOW_POWER |-> &off_bits && !boost_enable_out
        && serial_enable_out)
        else $error("wrong outputs in low power");
    lp_hold_a: assert property (
        power_state_out == PSTATE_LOW_POWER && !$past(reg_write_in.valid) && io_supply_in
        && $past(io_supply_in, 3) |=> power_state_out == PSTATE_LOW_POWER)
        else $error("low power left without a command");
    boost_read_a: assert property (
        reg_read_addr_in == REG_BOOST_LEVEL |=> !serial_enable_out || serial_reset_out
        || (reg_read_data_out[7:4] == 4'h0
        && boost_target_volts_out == BOOST_BASE_VOLTS + reg_read_data_out[3:0]))
        else $error("boost target does not match its code");
endmodule : power_ctrl_props
`default_nettype wire

/* File: tb/host_model.sv */
// Host controller model: issues register writes and reads.
// Assumes the block samples requests on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module host_model
    import power_ctrl_pkg::*;
(
    // Clock.
    input wire logic core_clk_in,
    // Register port towards the block.
    output reg_write_s reg_write_out,
    output logic [ADDR_W-1:0] reg_read_addr_out,
    input wire logic [CODE_W-1:0] reg_read_data_in
);
    initial begin
        reg_write_out = '0;
        reg_read_addr_out = '0;
    end
    // Whole one-cycle strobes; restarts only through the power-state command.
    task automatic write_reg(input logic [ADDR_W-1:0] addr, input logic [CODE_W-1:0] data);
        @(negedge core_clk_in);
        reg_write_out = {1'b1, addr, data};
        @(negedge core_clk_in);
        reg_write_out = '0;
    endtask : write_reg
    task automatic read_reg(input logic [ADDR_W-1:0] addr, output logic [CODE_W-1:0] data);
        @(negedge core_clk_in);
        reg_read_addr_out = addr;
        @(posedge core_clk_in);
        @(negedge core_clk_in);
        data = reg_read_data_in;
    endtask : read_reg
endmodule : host_model
`default_nettype wire

/* File: tb/power_mode_and_output_control_test.sv */
// Self-checking bench of the power mode and output control block.
// Assumes the host model drives the register port; main supply is dropped and raised once, in io_drop_test.
`timescale 1ns/1ps
`default_nettype none
module power_mode_and_output_control_test
    import power_ctrl_pkg::*;
;
    logic core_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic io_supply_in = 1'b0;
    logic main_supply_in = 1'b1;
    reg_write_s reg_write;
    logic [ADDR_W-1:0] read_addr;
    logic [CODE_W-1:0] read_data;
    logic serial_enable, serial_reset, boost_enable;
    logic [VOLTS_W-1:0] boost_volts;
    logic [STATE_W-1:0] power_state;
    channel_out_s [NUM_CHANNELS-1:0] channels;
    int fails = 0;
    int total_checks = 0;

    power_mode_and_output_control dut (
        .core_clk_in(core_clk_in), .reset_in(reset_in),
        .io_supply_in(io_supply_in), .main_supply_in(main_supply_in),
        .reg_write_in(reg_write), .reg_read_addr_in(read_addr),
        .reg_read_data_out(read_data), .serial_enable_out(serial_enable),
        .serial_reset_out(serial_reset), .boost_enable_out(boost_enable),
        .boost_target_volts_out(boost_volts), .power_state_out(power_state),
        .channels_out(channels)
    );
    host_model host (
        .core_clk_in(core_clk_in), .reg_write_out(reg_write),
        .reg_read_addr_out(read_addr), .reg_read_data_in(read_data)
    );

    initial begin
        forever #50 core_clk_in = ~core_clk_in;
    end

    task automatic report_and_stop;
        if (fails == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop

    task automatic check_val(input logic [16:0] got, input logic [16:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_val

    task automatic check_reg(input logic [ADDR_W-1:0] addr, input logic [CODE_W-1:0] exp);
        logic [CODE_W-1:0] rd;
        host.read_reg(addr, rd);
        check_val(17'(rd), 17'(exp));
    endtask : check_reg

    // Bounded wait; shutdown also reads as active, so callers wait for startup first.
    task automatic wait_state(input logic [STATE_W-1:0] code);
        int n;
        n = 0;
        while (power_state !== code && n < 40) begin
            @(negedge core_clk_in);
            n++;
        end
        check_val(17'(power_state), 17'(code));
    endtask : wait_state

    function automatic channel_out_s expect_ch(input logic on, input logic [7:0] code);
        logic [7:0] c;
        c = (code > CODE_MAX_USABLE) ? CODE_MAX_USABLE : code;
        // A disabled output still carries its level; only the drive mode changes.
        if (!on) return '{OUT_HIGH_Z, 15'(c) * OUT_STEP_MV};
        if (c == 8'h00) return '{OUT_PULL_DOWN, 15'h0000};
        return '{OUT_DRIVE, 15'(c) * OUT_STEP_MV};
    endfunction : expect_ch

    task automatic power_up;
        host.write_reg(REG_BOOST_LEVEL, 8'h03);
        @(negedge core_clk_in);
        io_supply_in = 1'b1;
        wait_state(PSTATE_STARTUP);
        wait_state(PSTATE_ACTIVE);
        check_reg(REG_BOOST_LEVEL, 8'h0F);
        check_val(17'(boost_volts), 17'h00018);
        check_reg(REG_OUTPUT_ENABLES, 8'h00);
        for (int i = 0; i < 6; i++) begin
            check_reg(REG_CHANNEL_A_CODE + 4'(i), CHANNEL_CODE_RESET);
            check_val(channels[i], expect_ch(1'b0, 8'h00));
        end
    endtask : power_up

    task automatic boost_test;
        for (int c = 0; c < 16; c++) begin
            host.write_reg(REG_BOOST_LEVEL, 8'(c));
            repeat (3) @(negedge core_clk_in);
            check_val(17'(boost_volts), 17'(c + 9));
        end
    endtask : boost_test

    task automatic channels_test;
        logic [7:0] codes [6] = '{8'h00, 8'h01, 8'h40, 8'h75, 8'h55, 8'hFF};
        host.write_reg(REG_OUTPUT_ENABLES, 8'h1F);
        for (int i = 0; i < 6; i++) begin
            host.write_reg(REG_CHANNEL_A_CODE + 4'(i), codes[i]);
        end
        repeat (3) @(negedge core_clk_in);
        for (int i = 0; i < 6; i++) begin
            check_val(channels[i], expect_ch(i < 5, codes[i]));
        end
        // The clamped code stays disabled; a code under the boost is driven instead.
        host.write_reg(REG_CHANNEL_F_CODE, 8'h55);
        host.write_reg(REG_OUTPUT_ENABLES, 8'h3F);
        repeat (3) @(negedge core_clk_in);
        check_val(channels[5], expect_ch(1'b1, 8'h55));
    endtask : channels_test

    task automatic low_power_test;
        host.write_reg(REG_POWER_STATE, 8'h02);
        wait_state(PSTATE_LOW_POWER);
        host.write_reg(REG_POWER_STATE, 8'h03);
        repeat (3) @(negedge core_clk_in);
        check_val(17'(power_state), 17'(PSTATE_LOW_POWER));
        check_val(17'({boost_enable, serial_enable, serial_reset}), 17'h00002);
        check_val(channels[3], expect_ch(1'b0, 8'h75));
        check_reg(REG_CHANNEL_A_CODE + 4'h3, 8'h75);
        host.write_reg(REG_POWER_STATE, 8'h00);
        wait_state(PSTATE_ACTIVE);
        repeat (2) @(negedge core_clk_in);
        check_val(channels[3], expect_ch(1'b1, 8'h75));
    endtask : low_power_test

    task automatic restart_test;
        host.write_reg(REG_POWER_STATE, 8'h01);
        wait_state(PSTATE_STARTUP);
        wait_state(PSTATE_ACTIVE);
        check_reg(REG_OUTPUT_ENABLES, 8'h00);
        check_reg(REG_CHANNEL_A_CODE + 4'h1, 8'h00);
    endtask : restart_test

    task automatic io_drop_test;
        host.write_reg(REG_BOOST_LEVEL, 8'h02);
        @(negedge core_clk_in);
        io_supply_in = 1'b0;
        repeat (6) @(negedge core_clk_in);
        check_val(17'({serial_enable, boost_enable}), 17'h00000);
        check_reg(REG_BOOST_LEVEL, 8'h00);
        host.write_reg(REG_OUTPUT_ENABLES, 8'h3F);
        @(negedge core_clk_in);
        io_supply_in = 1'b1;
        wait_state(PSTATE_STARTUP);
        wait_state(PSTATE_ACTIVE);
        check_reg(REG_BOOST_LEVEL, 8'h0F);
        check_reg(REG_OUTPUT_ENABLES, 8'h00);
        // A fresh main supply shuts the chip down even with the I/O supply up.
        main_supply_in = 1'b0;
        repeat (4) @(negedge core_clk_in);
        main_supply_in = 1'b1;
        repeat (6) @(negedge core_clk_in);
        check_val(17'({serial_enable, boost_enable}), 17'h00000);
        check_reg(REG_BOOST_LEVEL, 8'h00);
    endtask : io_drop_test

    initial begin
        repeat (12) @(negedge core_clk_in);
        reset_in = 1'b0;
        power_up();
        boost_test();
        channels_test();
        low_power_test();
        restart_test();
        io_drop_test();
        report_and_stop();
    end

    // The whole sequence needs well under a thousand cycles.
    initial begin
        repeat (4000) @(posedge core_clk_in);
        fails++;
        report_and_stop();
    end
endmodule : power_mode_and_output_control_test

bind power_mode_and_output_control power_ctrl_props chk (
    .core_clk_in, .reset_in, .io_supply_in, .reg_write_in, .reg_read_addr_in,
    .reg_read_data_out, .serial_enable_out, .serial_reset_out, .boost_enable_out,
    .boost_target_volts_out, .power_state_out, .channels_out
);
`default_nettype wire
